// File: hdl/peripheral_interrupt_regs.sv
// Peripheral interrupt flag and enable registers with a Wishbone slave
//
// The Wishbone slave port was left to the implementer.
`default_nettype none
module peripheral_interrupt_regs (
  input  wire logic                     clk_sys,
  input  wire logic                     rst_b,
  input  wire logic                     ce,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [7:0]               wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  input  wire irq_regs_pkg::events_type events,
  input  wire logic                     cmp_out,
  output logic                          core_irq_req,
  output logic                          irq
);
  irq_regs_pkg::regs_state_type st_r;
  irq_regs_pkg::regs_state_type st_nxt;

  logic       access;
  logic       commit;
  logic       wr_lo;
  logic       wr_flags;
  logic       rd_status;
  logic       cmp_sync;
  logic       cmp_change;
  logic [7:0] ev;
  logic [7:0] flags_q;
  logic [7:0] status_q;
  logic [7:0] rd_mux;

  // Comparator output is asynchronous to this clock
  level_sync u_cmp_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .ce      (ce),
    .din     (cmp_out),
    .dout    (cmp_sync)
  );

  // Request taken in first cycle, committed at the edge that sees ack
  assign access    = wb_cyc_i & wb_stb_i;
  assign commit    = access & st_r.ack;
  assign wr_lo     = commit & wb_we_i & wb_sel_i[0];
  assign wr_flags  = wr_lo & (wb_adr_i == irq_regs_pkg::ADDR_FLAGS);
  assign rd_status = commit & ~wb_we_i
                   & (wb_adr_i == irq_regs_pkg::ADDR_STATUS);

  // First sample after reset only primes; avoids a false change
  assign cmp_change = st_r.primed & (cmp_sync != st_r.cmp_prev);

  always_comb begin
    ev = 8'h00;
    ev[irq_regs_pkg::BIT_EEWRITE] = events.eewrite_done;
    ev[irq_regs_pkg::BIT_CONV]    = events.conv_done
                                  & irq_regs_pkg::HAS_CONVERTER;
    ev[irq_regs_pkg::BIT_CMP]     = cmp_change;
    ev[irq_regs_pkg::BIT_TIMER]   = events.timer_ovf;
  end

  // Flag and status bits exist only at implemented positions
  for (genvar i = 0; i < 8; i++) begin : g_bits
    if (irq_regs_pkg::IMPL_MASK[i]) begin : g_impl
      event_flag_bit u_flag (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .ce      (ce),
        .set_evt (ev[i]),
        .wr_en   (wr_flags),
        .wr_val  (wb_dat_i[i]),
        .flag    (flags_q[i])
      );
      // Read clears only bits that were returned, so no event is lost
      event_flag_bit u_status (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .ce      (ce),
        .set_evt (ev[i]),
        .wr_en   (rd_status & st_r.rdata[i]),
        .wr_val  (1'b0),
        .flag    (status_q[i])
      );
    end else begin : g_unimpl
      assign flags_q[i]  = 1'b0;
      assign status_q[i] = 1'b0;
    end
  end

  always_comb begin
    if (wb_adr_i == irq_regs_pkg::ADDR_FLAGS) begin
      rd_mux = flags_q;
    end else if (wb_adr_i == irq_regs_pkg::ADDR_ENABLES) begin
      rd_mux = st_r.enables;
    end else if (wb_adr_i == irq_regs_pkg::ADDR_CTRL) begin
      rd_mux = st_r.ctrl;
    end else if (wb_adr_i == irq_regs_pkg::ADDR_STATUS) begin
      rd_mux = status_q;
    end else if (wb_adr_i == irq_regs_pkg::ADDR_MASK) begin
      rd_mux = st_r.mask;
    end else begin
      rd_mux = irq_regs_pkg::RESET_BYTE;
    end
  end

  always_comb begin
    st_nxt          = st_r;
    st_nxt.ack      = access & ~st_r.ack;
    if (access & ~st_r.ack) begin
      st_nxt.rdata = rd_mux;
    end
    if (wr_lo) begin
      if (wb_adr_i == irq_regs_pkg::ADDR_ENABLES) begin
        st_nxt.enables = wb_dat_i[7:0]
                       & irq_regs_pkg::IMPL_MASK;
      end else if (wb_adr_i == irq_regs_pkg::ADDR_CTRL) begin
        st_nxt.ctrl = wb_dat_i[7:0] & irq_regs_pkg::CTRL_MASK;
      end else if (wb_adr_i == irq_regs_pkg::ADDR_MASK) begin
        st_nxt.mask = wb_dat_i[7:0] & irq_regs_pkg::IMPL_MASK;
      end
    end
    st_nxt.cmp_prev = cmp_sync;
    st_nxt.primed   = 1'b1;
    // Gated by both global enables; a flag alone never interrupts the core
    st_nxt.core_req = st_r.ctrl[irq_regs_pkg::BIT_GLOBAL]
                    & st_r.ctrl[irq_regs_pkg::BIT_PERIPH]
                    & (|(flags_q & st_r.enables));
    st_nxt.irq      = |(status_q & st_r.mask);
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign wb_dat_o     = {24'h00_0000, st_r.rdata};
  assign wb_ack_o     = st_r.ack;
  assign core_irq_req = st_r.core_req;
  assign irq          = st_r.irq;

  // Checks of the documented behaviour
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  a_unimpl_bits_zero: assert property (
    ((flags_q & ~irq_regs_pkg::IMPL_MASK) == 8'h00)
    && ((st_r.enables & ~irq_regs_pkg::IMPL_MASK) == 8'h00))
    else $error("unimplemented bit is set");

  a_enable_write: assert property (
    (ce && wr_lo && wb_adr_i == irq_regs_pkg::ADDR_ENABLES)
    |=> st_r.enables == ($past(wb_dat_i[7:0]) & irq_regs_pkg::IMPL_MASK))
    else $error("enable register did not take the write");

  a_flag_readback: assert property (
    (ce && access && !st_r.ack && wb_adr_i == irq_regs_pkg::ADDR_FLAGS)
    |=> wb_ack_o && wb_dat_o[7:0] == $past(flags_q))
    else $error("flag register read returned wrong data");

  a_eewrite_flag: assert property (
    (ce && events.eewrite_done)
    |=> flags_q[irq_regs_pkg::BIT_EEWRITE])
    else $error("write-complete event did not set its flag");

  a_conv_flag: assert property (
    (ce && events.conv_done && irq_regs_pkg::HAS_CONVERTER)
    |=> flags_q[irq_regs_pkg::BIT_CONV])
    else $error("conversion event did not set its flag");

  a_cmp_flag: assert property (
    (ce && cmp_change) |=> flags_q[irq_regs_pkg::BIT_CMP])
    else $error("comparator change did not set its flag");

  a_timer_flag_set: assert property (
    (ce && events.timer_ovf && !st_r.enables[irq_regs_pkg::BIT_TIMER])
    |=> flags_q[irq_regs_pkg::BIT_TIMER])
    else $error("disabled overflow event did not set its flag");

  a_timer_flag_hold: assert property (
    (ce && flags_q[irq_regs_pkg::BIT_TIMER] && !wr_flags)
    |=> flags_q[irq_regs_pkg::BIT_TIMER])
    else $error("overflow flag dropped without a write");

  a_periph_gate_off: assert property (
    (ce && !st_r.ctrl[irq_regs_pkg::BIT_PERIPH]) |=> !core_irq_req)
    else $error("request passed with peripheral enable clear");

  a_periph_gate_on: assert property (
    (ce && st_r.ctrl[irq_regs_pkg::BIT_GLOBAL]
     && st_r.ctrl[irq_regs_pkg::BIT_PERIPH]
     && (flags_q & st_r.enables) != 8'h00) |=> core_irq_req)
    else $error("enabled pending flag did not raise the request");

  a_masked_off: assert property (
    (ce && (flags_q & st_r.enables) == 8'h00) |=> !core_irq_req)
    else $error("request raised with no enabled flag");

  a_ack_single: assert property (
    (ce && wb_ack_o) |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  a_status_irq: assert property (
    (ce && events.timer_ovf && st_r.mask[irq_regs_pkg::BIT_TIMER]) ##1
    (ce && st_r.mask[irq_regs_pkg::BIT_TIMER]) |=> irq)
    else $error("masked-in event did not raise irq");

  a_ack_latency: assert property (
    (ce && access && !st_r.ack) |=> wb_ack_o)
    else $error("request taken but no ack one cycle later");

  a_ack_idle: assert property (
    (ce && !access) |=> !wb_ack_o)
    else $error("ack raised without a request");

  // Master may sample late; data must not drift between requests
  a_rdata_hold: assert property (
    !(ce && access && !st_r.ack) |=> $stable(wb_dat_o))
    else $error("read data changed without a new request");

  a_enable_readback: assert property (
    (ce && access && !st_r.ack && wb_adr_i == irq_regs_pkg::ADDR_ENABLES)
    |=> wb_dat_o[7:0] == $past(st_r.enables))
    else $error("enable register read returned wrong data");

  a_enable_hold: assert property (
    !(ce && wr_lo && wb_adr_i == irq_regs_pkg::ADDR_ENABLES)
    |=> $stable(st_r.enables))
    else $error("enable register changed without a write");

  a_flags_write: assert property (
    (ce && wr_flags && ev == 8'h00)
    |=> flags_q == ($past(wb_dat_i[7:0]) & irq_regs_pkg::IMPL_MASK))
    else $error("flag register did not take the write");

  a_ctrl_write: assert property (
    (ce && wr_lo && wb_adr_i == irq_regs_pkg::ADDR_CTRL)
    |=> st_r.ctrl == ($past(wb_dat_i[7:0]) & irq_regs_pkg::CTRL_MASK))
    else $error("control register did not take the write");

  a_mask_write: assert property (
    (ce && wr_lo && wb_adr_i == irq_regs_pkg::ADDR_MASK)
    |=> st_r.mask == ($past(wb_dat_i[7:0]) & irq_regs_pkg::IMPL_MASK))
    else $error("mask register did not take the write");

  a_conv_flag_any: assert property (
    (ce && events.conv_done && irq_regs_pkg::HAS_CONVERTER
     && !st_r.ctrl[irq_regs_pkg::BIT_GLOBAL])
    |=> flags_q[irq_regs_pkg::BIT_CONV])
    else $error("conversion flag waited for the global enable");

  a_eewrite_hold: assert property (
    (flags_q[irq_regs_pkg::BIT_EEWRITE] && !wr_flags)
    |=> flags_q[irq_regs_pkg::BIT_EEWRITE])
    else $error("write-complete flag dropped without a write");

  a_conv_hold: assert property (
    (flags_q[irq_regs_pkg::BIT_CONV] && !wr_flags)
    |=> flags_q[irq_regs_pkg::BIT_CONV])
    else $error("conversion flag dropped without a write");

  a_cmp_hold: assert property (
    (flags_q[irq_regs_pkg::BIT_CMP] && !wr_flags)
    |=> flags_q[irq_regs_pkg::BIT_CMP])
    else $error("comparator flag dropped without a write");

  // Only a real edge of the synchronised level, or a write of 1, may set this flag
  a_cmp_no_false: assert property (
    (ce && !cmp_change && !flags_q[irq_regs_pkg::BIT_CMP]
     && !(wr_flags && wb_dat_i[irq_regs_pkg::BIT_CMP]))
    |=> !flags_q[irq_regs_pkg::BIT_CMP])
    else $error("comparator flag set with no change");

  a_global_gate_off: assert property (
    (ce && !st_r.ctrl[irq_regs_pkg::BIT_GLOBAL]) |=> !core_irq_req)
    else $error("request passed with global enable clear");

  // Set wins over the read clear, so only a quiet cycle is checked
  a_status_read_clr: assert property (
    (ce && rd_status && st_r.rdata[irq_regs_pkg::BIT_TIMER]
     && !ev[irq_regs_pkg::BIT_TIMER])
    |=> !status_q[irq_regs_pkg::BIT_TIMER])
    else $error("read of status did not clear the returned bit");

  a_irq_off: assert property (
    (ce && (status_q & st_r.mask) == 8'h00) |=> !irq)
    else $error("irq raised with no unmasked status bit");

  a_other_bits_zero: assert property (
    ((status_q & ~irq_regs_pkg::IMPL_MASK) == 8'h00)
    && ((st_r.mask & ~irq_regs_pkg::IMPL_MASK) == 8'h00)
    && ((st_r.ctrl & ~irq_regs_pkg::CTRL_MASK) == 8'h00))
    else $error("bit outside a register's layout is set");

  // Ce low must hold every flop, the per-bit flag cells included
  a_freeze_hold: assert property (
    !ce |=> $stable(st_r) && $stable(flags_q) && $stable(status_q))
    else $error("state moved while clock enable was low");
endmodule : peripheral_interrupt_regs
`default_nettype wire

// File: hdl/irq_regs_pkg.sv
// Constants and types shared by the peripheral interrupt register block
`default_nettype none
package irq_regs_pkg;
  localparam logic [7:0] ADDR_FLAGS   = 8'h0c;
  localparam logic [7:0] ADDR_ENABLES = 8'h8c;
  localparam logic [7:0] ADDR_CTRL    = 8'h10;
  localparam logic [7:0] ADDR_STATUS  = 8'h14;
  localparam logic [7:0] ADDR_MASK    = 8'h18;

  localparam int unsigned BIT_EEWRITE = 7;
  localparam int unsigned BIT_CONV    = 6;
  localparam int unsigned BIT_CMP     = 3;
  localparam int unsigned BIT_TIMER   = 0;
  localparam int unsigned BIT_GLOBAL  = 7;
  localparam int unsigned BIT_PERIPH  = 6;

  localparam logic [7:0] IMPL_MASK  = 8'hc9;
  localparam logic [7:0] CTRL_MASK  = 8'hc0;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic       HAS_CONVERTER = 1'b1;

  typedef struct packed {
    logic eewrite_done;
    logic conv_done;
    logic timer_ovf;
  } events_type;

  typedef struct packed {
    logic stage1;
    logic stage2;
  } sync_state_type;

  typedef struct packed {
    logic flag;
  } flag_state_type;

  typedef struct packed {
    logic [7:0] enables;
    logic [7:0] ctrl;
    logic [7:0] mask;
    logic [7:0] rdata;
    logic       ack;
    logic       cmp_prev;
    logic       primed;
    logic       core_req;
    logic       irq;
  } regs_state_type;
endpackage : irq_regs_pkg
`default_nettype wire

// File: hdl/level_sync.sv
// Two-stage synchroniser for an asynchronous level
`default_nettype none
module level_sync (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic ce,
  input  wire logic din,
  output logic      dout
);
  irq_regs_pkg::sync_state_type st_r;
  irq_regs_pkg::sync_state_type st_nxt;

  always_comb begin
    st_nxt        = st_r;
    st_nxt.stage1 = din;
    st_nxt.stage2 = st_r.stage1;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.stage2;
endmodule : level_sync
`default_nettype wire

// File: hdl/event_flag_bit.sv
// One sticky flag bit: hardware set beats software write or clear
`default_nettype none
module event_flag_bit (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic ce,
  input  wire logic set_evt,
  input  wire logic wr_en,
  input  wire logic wr_val,
  output logic      flag
);
  irq_regs_pkg::flag_state_type st_r;
  irq_regs_pkg::flag_state_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (set_evt) begin
      st_nxt.flag = 1'b1;
    end else if (wr_en) begin
      st_nxt.flag = wr_val;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign flag = st_r.flag;
endmodule : event_flag_bit
`default_nettype wire

// File: testbench/event_source_model.sv
// Model of the peripheral event sources facing the interrupt registers
`default_nettype none
module event_source_model (
  input  wire logic                     clk_sys,
  input  wire logic                     rst_b,
  input  wire irq_regs_pkg::events_type fire,
  input  wire logic                     flip_cmp,
  output var  irq_regs_pkg::events_type events,
  output var  logic                     cmp_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Completion sources emit one-cycle pulses on the core clock
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      events  <= '0;
      cmp_out <= 1'b0;
    end else begin
      events <= fire;
      if (flip_cmp) begin
        cmp_out <= ~cmp_out;
      end
    end
  end
endmodule : event_source_model
`default_nettype wire

// File: testbench/tb_peripheral_interrupt_regs.sv
// Self-checking bench for the peripheral interrupt registers
`default_nettype none
module tb_peripheral_interrupt_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic                     clk_sys, rst_b, ce, cyc, stb, we, flip_cmp;
  logic                     ack, core_irq_req, irq, cmp_out;
  logic [7:0]               adr;
  logic [31:0]              wdat, rdat, dat_o;
  irq_regs_pkg::events_type fire, events;
  int                       n_fail, n_checks;
  localparam logic [7:0] FL = irq_regs_pkg::ADDR_FLAGS;
  localparam logic [7:0] EN = irq_regs_pkg::ADDR_ENABLES;
  localparam logic [7:0] CT = irq_regs_pkg::ADDR_CTRL;
  localparam logic [7:0] ST = irq_regs_pkg::ADDR_STATUS;
  localparam logic [7:0] MK = irq_regs_pkg::ADDR_MASK;

  peripheral_interrupt_regs i_dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .events(events), .cmp_out(cmp_out),
    .core_irq_req(core_irq_req), .irq(irq));
  event_source_model i_src (.clk_sys(clk_sys), .rst_b(rst_b),
    .fire(fire), .flip_cmp(flip_cmp), .events(events), .cmp_out(cmp_out));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic chk_byte(input string n, input logic [7:0] e, g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk_byte

  // Level outputs are looked at mid-cycle, once the edge has settled
  task automatic chk_bit(input string n, input logic e, g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, g);
    end
  endtask : chk_bit

  task automatic wb(input logic w, input logic [7:0] a, d);
    @(posedge clk_sys);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h00_0000, d};
    @(posedge clk_sys iff ack === 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb

  task automatic rd_chk(input string n, input logic [7:0] a, e);
    wb(1'b0, a, 8'h00);
    chk_byte(n, e, rdat[7:0]);
  endtask : rd_chk

  task automatic settle();
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : settle

  task automatic pulse(input irq_regs_pkg::events_type e);
    @(posedge clk_sys);
    fire <= e;
    @(posedge clk_sys);
    fire <= '0;
    repeat (2) @(posedge clk_sys);
  endtask : pulse

  task automatic t_reset();
    rd_chk("flags", FL, 8'h00);
    rd_chk("enables", EN, 8'h00);
    settle();
    chk_bit("core_irq_req", 1'b0, core_irq_req);
    chk_bit("irq", 1'b0, irq);
  endtask : t_reset

  task automatic t_rw();
    wb(1'b1, EN, 8'hff);
    rd_chk("enables", EN, 8'hc9);
    wb(1'b1, EN, 8'h00);
    rd_chk("enables", EN, 8'h00);
    wb(1'b1, FL, 8'hff);
    rd_chk("flags", FL, 8'hc9);
    wb(1'b1, FL, 8'h00);
    rd_chk("flags", FL, 8'h00);
    wb(1'b1, 8'h40, 8'hff);
    rd_chk("unmapped", 8'h40, 8'h00);
  endtask : t_rw

  task automatic t_events();
    pulse(3'h4);
    rd_chk("flags", FL, 8'h80);
    pulse(3'h2);
    rd_chk("flags", FL, 8'hc0);
    pulse(3'h1);
    rd_chk("flags", FL, 8'hc1);
    @(posedge clk_sys);
    flip_cmp <= 1'b1;
    @(posedge clk_sys);
    flip_cmp <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rd_chk("flags", FL, 8'hc9);
    wb(1'b1, FL, 8'h00);
  endtask : t_events

  task automatic t_gate();
    logic [7:0] m;
    for (int i = 0; i < 4; i++) begin
      m = 8'h01 << irq_regs_pkg::BIT_TIMER;
      if (i == 1) m = 8'h08;
      if (i == 2) m = 8'h40;
      if (i == 3) m = 8'h80;
      wb(1'b1, FL, m);
      wb(1'b1, CT, 8'hc0);
      wb(1'b1, EN, 8'hc9 ^ m);
      settle();
      chk_bit("core_irq_req", 1'b0, core_irq_req);
      wb(1'b1, EN, m);
      rd_chk("enables", EN, m);
      for (int c = 0; c < 4; c++) begin
        wb(1'b1, CT, 8'(c << 6));
        settle();
        chk_bit("core_irq_req", c == 3, core_irq_req);
      end
      wb(1'b1, FL, 8'h00);
    end
    wb(1'b1, CT, 8'h00);
  endtask : t_gate

  task automatic t_irq();
    rd_chk("status", ST, 8'hc9);
    rd_chk("status", ST, 8'h00);
    wb(1'b1, MK, 8'h01);
    pulse(3'h1);
    settle();
    chk_bit("irq", 1'b1, irq);
    wb(1'b1, MK, 8'h00);
    settle();
    chk_bit("irq", 1'b0, irq);
    wb(1'b1, MK, 8'h01);
    rd_chk("status", ST, 8'h01);
    settle();
    chk_bit("irq", 1'b0, irq);
    wb(1'b1, FL, 8'h00);
  endtask : t_irq

  // An event that arrives while the clock enable is low is not seen
  task automatic t_freeze();
    @(posedge clk_sys);
    ce <= 1'b0;
    pulse(3'h1);
    @(posedge clk_sys);
    ce <= 1'b1;
    rd_chk("flags", FL, 8'h00);
    rd_chk("status", ST, 8'h00);
  endtask : t_freeze

  // Reset in mid-run clears a live request and the flag, enable and control registers
  task automatic t_midreset();
    wb(1'b1, EN, 8'h09);
    wb(1'b1, FL, 8'h01);
    wb(1'b1, CT, 8'hc0);
    settle();
    chk_bit("core_irq_req", 1'b1, core_irq_req);
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reset();
    rd_chk("ctrl", CT, 8'h00);
  endtask : t_midreset

  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  // Whole run needs a few hundred cycles; this cuts a lost ack short
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    wrap_up();
  end

  initial begin
    n_fail = 0;
    n_checks = 0;
    rst_b = 1'b0;
    ce = 1'b1;
    {cyc, stb, we, flip_cmp} = 4'h0;
    adr = 8'h00;
    wdat = 32'h0000_0000;
    fire = '0;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reset();
    t_rw();
    t_events();
    t_gate();
    t_irq();
    t_freeze();
    t_midreset();
    wrap_up();
  end
endmodule : tb_peripheral_interrupt_regs
`default_nettype wire
